// ### rtl/gmc_params.svh
// Timing constants and widths for the gate motion controller.
`ifndef GMC_PARAMS_SVH
`define GMC_PARAMS_SVH

// System clock rate in MHz.
`define GMC_CLK_MHZ 250
// Pre-warning interval in milliseconds.
`define GMC_PREWARN_MS 5000
// Pre-warning interval in clock cycles, derived from the two figures above.
`define GMC_PREWARN_CYCLES (`GMC_PREWARN_MS * `GMC_CLK_MHZ * 1000)
// Width of the pre-warning timer.
`define GMC_TIMER_W 32
// Number of field contacts passing the synchroniser.
`define GMC_NUM_CONTACTS 6

`endif

// ### rtl/gmc_pkg.sv
// Types shared by the gate motion controller files.
package gmc_pkg;

   // Controller states: idle, pre-warning before each direction, and travel.
   typedef enum logic [2:0] {
      GMC_IDLE,
      GMC_WARN_OPEN,
      GMC_WARN_CLOSE,
      GMC_OPENING,
      GMC_CLOSING
   } gmc_state_t;

endpackage

// ### rtl/gmc_sync.sv
// Two-stage synchroniser for a group of asynchronous contact levels.
module gmc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // Raw and synchronised levels.
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // Reset shows all levels low, which reads as an actuated stop contact.
   always_comb begin
      meta_next = d;
      sync_next = meta_reg;
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge mclk) begin
      if (reset) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign q = sync_reg;

endmodule

// ### rtl/gmc_ctrl.sv
// Gate motion controller: requests, end contacts, safety bar and warning lamp.
`include "gmc_params.svh"

module gmc_ctrl #(
   parameter int unsigned PREWARN_CYCLES = `GMC_PREWARN_CYCLES,
   parameter bit ENHANCED = 1'b1
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // Field contacts, raw from the pins.
   input wire logic stop_contact,
   input wire logic open_request_contact,
   input wire logic close_request_contact,
   input wire logic opened_end_contact,
   input wire logic closed_end_contact,
   input wire logic safety_bar_contact,
   // Contactor and lamp drives.
   output logic drive_open,
   output logic drive_close,
   output logic warning_lamp,
   // Controller state for observation.
   output gmc_pkg::gmc_state_t gate_state
);
   import gmc_pkg::*;

   // Refuse an empty pre-warning of zero cycles.
   if (PREWARN_CYCLES < 1) begin : g_bad_prewarn
      $error("PREWARN_CYCLES must be at least one");
   end

   logic [`GMC_NUM_CONTACTS-1:0] raw;
   logic [`GMC_NUM_CONTACTS-1:0] sync;
   logic stop_act;
   logic open_req;
   logic close_req;
   logic open_end;
   logic close_end;
   logic bar_act;
   gmc_state_t state_reg;
   gmc_state_t state_next;
   logic [`GMC_TIMER_W-1:0] timer_reg;
   logic [`GMC_TIMER_W-1:0] timer_next;
   logic drive_open_reg;
   logic drive_open_next;
   logic drive_close_reg;
   logic drive_close_next;
   logic lamp_reg;
   logic lamp_next;
   logic timer_done;

   // Every contact passes two flip-flops before any logic reads it.
   assign raw = {safety_bar_contact, closed_end_contact, opened_end_contact,
                 close_request_contact, open_request_contact, stop_contact};

   gmc_sync #(
      .WIDTH(`GMC_NUM_CONTACTS)
   ) u_sync (
      .mclk(mclk),
      .reset(reset),
      .d(raw),
      .q(sync)
   );

   // Normally closed contacts read low when actuated or when a wire breaks,
   // so a broken loop behaves as a pressed stop, a reached end or an actuated bar.
   assign stop_act = ~sync[0];
   assign open_req = sync[1];
   assign close_req = sync[2];
   assign open_end = ~sync[3];
   assign close_end = ~sync[4];
   assign bar_act = ~sync[5];

   assign timer_done = (timer_reg == (PREWARN_CYCLES - 1));

   // Next state, timer and drive values.
   always_comb begin
      state_next = state_reg;
      timer_next = '0;
      case (state_reg)
         GMC_IDLE: begin
            // Open wins when both buttons are pressed together.
            if (!stop_act && open_req && !open_end) begin
               state_next = GMC_WARN_OPEN;
            end else if (!stop_act && close_req && !close_end && !bar_act) begin
               state_next = GMC_WARN_CLOSE;
            end
         end
         GMC_WARN_OPEN: begin
            // Close requests are ignored while an opening is under way.
            if (stop_act || open_end) begin
               state_next = GMC_IDLE;
            end else if (timer_done) begin
               state_next = GMC_OPENING;
            end else begin
               timer_next = timer_reg + 1'b1;
            end
         end
         GMC_WARN_CLOSE: begin
            if (stop_act || close_end) begin
               state_next = GMC_IDLE;
            end else if (bar_act) begin
               state_next = ENHANCED ? GMC_WARN_OPEN : GMC_IDLE;
            end else if (timer_done) begin
               state_next = GMC_CLOSING;
            end else begin
               timer_next = timer_reg + 1'b1;
            end
         end
         GMC_OPENING: begin
            // Travel runs on without the button held, until an end or stop.
            if (stop_act || open_end) begin
               state_next = GMC_IDLE;
            end
         end
         GMC_CLOSING: begin
            if (stop_act || close_end) begin
               state_next = GMC_IDLE;
            end else if (bar_act) begin
               // Reversal still gets a full warning before the gate moves again.
               state_next = ENHANCED ? GMC_WARN_OPEN : GMC_IDLE;
            end
         end
         default: begin
            state_next = GMC_IDLE;
         end
      endcase
      drive_open_next = (state_next == GMC_OPENING);
      // The bar term is redundant with the state logic but keeps the close
      // contactor off even if the state decode were ever wrong.
      drive_close_next = (state_next == GMC_CLOSING) && !bar_act;
      lamp_next = (state_next != GMC_IDLE);
   end

   // State registers.
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= GMC_IDLE;
         timer_reg <= '0;
         drive_open_reg <= 1'b0;
         drive_close_reg <= 1'b0;
         lamp_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         drive_open_reg <= drive_open_next;
         drive_close_reg <= drive_close_next;
         lamp_reg <= lamp_next;
      end
   end

   assign drive_open = drive_open_reg;
   assign drive_close = drive_close_reg;
   assign warning_lamp = lamp_reg;
   assign gate_state = state_reg;

   // Helper: consecutive cycles the lamp has been on, saturating.
   logic [`GMC_TIMER_W-1:0] lamp_run_reg;
   logic [`GMC_TIMER_W-1:0] lamp_run_next;

   always_comb begin
      lamp_run_next = '0;
      if (lamp_reg) begin
         lamp_run_next = (&lamp_run_reg) ? lamp_run_reg : lamp_run_reg + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         lamp_run_reg <= '0;
      end else begin
         lamp_run_reg <= lamp_run_next;
      end
   end

   // Checks on the drives, the lamp and the state sequence.
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   property p_one_drive;
      !(drive_open_reg && drive_close_reg);
   endproperty
   a_one_drive: assert property (p_one_drive) else $error("both drives on");

   property p_start_open;
      (state_reg == GMC_IDLE) && !stop_act && open_req && !open_end
         |=> (state_reg == GMC_WARN_OPEN) && warning_lamp && !drive_open;
   endproperty
   a_start_open: assert property (p_start_open) else $error("open start missed");

   property p_ignore_close;
      (state_reg == GMC_OPENING) && close_req && !stop_act && !open_end
         |=> drive_open_reg && !drive_close_reg;
   endproperty
   a_ignore_close: assert property (p_ignore_close) else $error("opening broken");

   property p_stop;
      stop_act |=> !drive_open_reg && !drive_close_reg;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured");

   property p_open_end;
      drive_open_reg && open_end |=> !drive_open_reg ##1 !drive_open_reg;
   endproperty
   a_open_end: assert property (p_open_end) else $error("open end ignored");

   property p_keep_closing;
      drive_close_reg && !stop_act && !close_end && !bar_act |=> drive_close_reg;
   endproperty
   a_keep_closing: assert property (p_keep_closing) else $error("close dropped");

   property p_prewarn;
      $rose(drive_open_reg) || $rose(drive_close_reg)
         |-> lamp_run_reg >= PREWARN_CYCLES;
   endproperty
   a_prewarn: assert property (p_prewarn) else $error("drive before warning");

   property p_lamp_moving;
      drive_open_reg || drive_close_reg |-> warning_lamp;
   endproperty
   a_lamp_moving: assert property (p_lamp_moving) else $error("lamp off in motion");

   property p_bar_close;
      bar_act |=> !drive_close_reg;
   endproperty
   a_bar_close: assert property (p_bar_close) else $error("closing on bar");

   property p_reverse;
      ENHANCED && drive_close_reg && bar_act && !stop_act && !close_end
         |=> (state_reg == GMC_WARN_OPEN) && warning_lamp;
   endproperty
   a_reverse: assert property (p_reverse) else $error("no reversal");

   // Main scenarios.
   c_open_run: cover property ($rose(drive_open_reg));
   c_close_run: cover property ($rose(drive_close_reg));
   c_reverse: cover property (drive_close_reg && bar_act ##1 state_reg == GMC_WARN_OPEN);
   c_stop_mid: cover property (drive_open_reg && stop_act && !open_end);

endmodule

// ### verif/gmc_gate_model.sv
// Field model of the gate: travel position and the two end contacts.
module gmc_gate_model #(
   parameter int TRAVEL = 20
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // Contactor drives.
   input wire logic drive_open,
   input wire logic drive_close,
   // End contacts and position.
   output logic opened_end_contact,
   output logic closed_end_contact,
   output int pos
);
   timeunit 1ns;
   timeprecision 1ps;
   // One step a cycle while a contactor pulls in; the leaf halts at each end.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pos <= 0;
      end else if (drive_open && pos < TRAVEL) begin
         pos <= pos + 1;
      end else if (drive_close && pos > 0) begin
         pos <= pos - 1;
      end
   end
   // Normally closed, so a broken wire also reads as an end reached.
   assign opened_end_contact = (pos != TRAVEL);
   assign closed_end_contact = (pos != 0);
endmodule

// ### verif/gmc_ctrl_tb.sv
// Self-checking bench for the gate motion controller.
module gmc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gmc_pkg::*;
   localparam int PRE = 8;
   localparam int TRAVEL = 20;
   logic mclk = 0, reset = 1;
   logic stop_contact = 1, open_req = 0, close_req = 0, bar = 1;
   logic opened_end, closed_end, drive_open, drive_close, warning_lamp;
   logic b_opened_end, b_closed_end, b_drive_open, b_drive_close, b_lamp;
   gmc_state_t gate_state;
   gmc_state_t b_state;
   int pos, err_total = 0, checks = 0, cyc = 0, n;
   int b_pos;
   // Field contacts are normally closed, requests normally open.
   gmc_ctrl #(.PREWARN_CYCLES(PRE), .ENHANCED(1'b1)) i_dut (.mclk(mclk), .reset(reset),
      .stop_contact(stop_contact), .open_request_contact(open_req),
      .close_request_contact(close_req), .opened_end_contact(opened_end),
      .closed_end_contact(closed_end), .safety_bar_contact(bar), .drive_open(drive_open),
      .drive_close(drive_close), .warning_lamp(warning_lamp), .gate_state(gate_state));
   gmc_gate_model #(.TRAVEL(TRAVEL)) i_gate (.mclk(mclk), .reset(reset),
      .drive_open(drive_open), .drive_close(drive_close), .opened_end_contact(opened_end),
      .closed_end_contact(closed_end), .pos(pos));
   // The basic variant shares every button and differs only in its bar reaction.
   gmc_ctrl #(.PREWARN_CYCLES(PRE), .ENHANCED(1'b0)) i_dut_basic (.mclk(mclk), .reset(reset),
      .stop_contact(stop_contact), .open_request_contact(open_req),
      .close_request_contact(close_req), .opened_end_contact(b_opened_end),
      .closed_end_contact(b_closed_end), .safety_bar_contact(bar),
      .drive_open(b_drive_open), .drive_close(b_drive_close), .warning_lamp(b_lamp),
      .gate_state(b_state));
   gmc_gate_model #(.TRAVEL(TRAVEL)) i_gate_basic (.mclk(mclk), .reset(reset),
      .drive_open(b_drive_open), .drive_close(b_drive_close),
      .opened_end_contact(b_opened_end), .closed_end_contact(b_closed_end), .pos(b_pos));
   // Clock at 250 MHz.
   always #2 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Ceiling well above the hundred-odd cycles the tests need.
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         err_total++;
         test_done();
      end
   end
   // The lamp must be on in every cycle that a contactor is pulled in.
   always @(negedge mclk) begin
      if (!reset && (drive_open || drive_close)) begin
         check(warning_lamp, 1'b1, "lamp during motion");
      end
      if (!reset && (b_drive_open || b_drive_close)) begin
         check(b_lamp, 1'b1, "basic lamp during motion");
      end
   end
   // A short press; the controller latches it, so the button need not be held.
   task automatic press(input bit up);
      @(posedge mclk);
      if (up) open_req <= 1; else close_req <= 1;
      repeat (4) @(posedge mclk);
      open_req <= 0;
      close_req <= 0;
   endtask
   task automatic wait_state(input gmc_state_t s, input int limit, input string msg);
      n = 0;
      while (gate_state !== s && n < limit) begin
         @(negedge mclk);
         n++;
      end
      check(gate_state, s, msg);
   endtask
   // Open from closed: exact pre-warning, opposite request ignored, runs to the end.
   task automatic t_open();
      press(1'b1);
      wait_state(GMC_WARN_OPEN, 8, "warn open");
      n = 0;
      while (!drive_open && n < PRE + 4) begin
         check(warning_lamp, 1'b1, "lamp before motion");
         @(negedge mclk);
         n++;
      end
      check(n, PRE, "prewarning length");
      press(1'b0);
      @(negedge mclk);
      check(gate_state, GMC_OPENING, "close ignored while opening");
      wait_state(GMC_IDLE, TRAVEL + 8, "idle at open end");
      check(pos, TRAVEL, "fully open");
      check(warning_lamp, 1'b0, "lamp off at rest");
      $display("test t_open done");
   endtask
   // Close and halt midway with the stop button.
   task automatic t_stop();
      press(1'b0);
      wait_state(GMC_CLOSING, PRE + 8, "closing");
      repeat (5) @(posedge mclk);
      stop_contact <= 0;
      repeat (4) @(negedge mclk);
      check({drive_open, drive_close}, 2'b00, "drives off after stop");
      check(pos > 0 && pos < TRAVEL, 1'b1, "halted partway");
      @(posedge mclk);
      stop_contact <= 1;
      $display("test t_stop done");
   endtask
   // Safety bar while closing: the enhanced gate reopens, the basic one halts in place.
   // A close request on the actuated bar is refused by both.
   task automatic t_bar();
      press(1'b0);
      wait_state(GMC_CLOSING, PRE + 8, "closing again");
      @(posedge mclk);
      bar <= 0;
      repeat (4) @(negedge mclk);
      check(drive_close, 1'b0, "close dropped on bar");
      check(gate_state, GMC_WARN_OPEN, "reverse warning");
      check(b_state, GMC_IDLE, "basic halts on bar");
      check({b_drive_close, b_lamp}, 2'b00, "basic drive and lamp off");
      wait_state(GMC_IDLE, TRAVEL + PRE + 12, "reopened");
      check(pos, TRAVEL, "back to fully open");
      check(b_pos > 0 && b_pos < TRAVEL, 1'b1, "basic stays partway");
      press(1'b0);
      repeat (6) @(negedge mclk);
      check(gate_state, GMC_IDLE, "close refused on bar");
      check(b_state, GMC_IDLE, "basic close refused on bar");
      @(posedge mclk);
      bar <= 1;
      $display("test t_bar done");
   endtask
   // Reset for 16 cycles, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 0;
      repeat (4) @(negedge mclk);
      check(gate_state, GMC_IDLE, "idle after reset");
      check(b_state, GMC_IDLE, "basic idle after reset");
      t_open();
      t_stop();
      t_bar();
      test_done();
   end
endmodule
